/* File: design/hutb_pkg.sv */
// Shared constants, baud table and helper functions for the UART transport bridge.
package hutb_pkg;
  localparam int unsigned HUTB_CLK_HZ = 200000000;
  localparam int HUTB_NRATES = 17;
  localparam int unsigned HUTB_RATE [HUTB_NRATES] = '{
    9600, 14400, 19200, 28800, 38400, 57600, 115200, 230400, 460800, 921600,
    144444, 150000, 2000000, 3000000, 3250000, 3692000, 4000000};
  localparam logic [4:0] HUTB_IDX_DEFAULT = 5'h06;
  localparam int HUTB_FIFO_DEPTH = 64;
  localparam int HUTB_FIFO_WIDTH = 8;
  localparam int HUTB_RTS_MARGIN = 4;
  localparam logic [3:0] HUTB_LAST_TX_BIT = 4'h9;
  localparam logic [3:0] HUTB_LAST_RX_DATA = 4'h8;
  localparam logic [15:0] HUTB_AB_MAX = 16'hFFFF;

  // Cycles per bit at the reference clock, rounded to nearest.
  function automatic logic [15:0] hutb_div(input logic [4:0] idx);
    int unsigned r;
    r = (int'(idx) < HUTB_NRATES) ? HUTB_RATE[idx] : HUTB_RATE[HUTB_IDX_DEFAULT];
    return 16'((HUTB_CLK_HZ + r / 2) / r);
  endfunction : hutb_div

  // Table entry whose bit time lies closest to a measured low run.
  function automatic logic [4:0] hutb_nearest(input logic [15:0] len);
    logic [4:0] best;
    logic [15:0] bd;
    logic [15:0] d;
    logic [15:0] dv;
    best = HUTB_IDX_DEFAULT;
    bd = HUTB_AB_MAX;
    for (int i = 0; i < HUTB_NRATES; i++) begin
      dv = hutb_div(5'(i));
      d = (len > dv) ? len - dv : dv - len;
      if (d < bd) begin
        bd = d;
        best = 5'(i);
      end
    end
    return best;
  endfunction : hutb_nearest
endpackage : hutb_pkg

/* File: design/hutb_link_if.sv */
// Four-wire serial link between the device end and the host end.
`timescale 1ns/1ps
interface hutb_link_if;
  logic dev_txd;
  logic host_txd;
  logic dev_rts_n;
  logic host_rts_n;
  modport dev (output dev_txd, output dev_rts_n, input host_txd, input host_rts_n);
  modport host (output host_txd, output host_rts_n, input dev_txd, input dev_rts_n);
endinterface : hutb_link_if

/* File: design/hutb_dev.sv */
// Device end of the UART transport: FIFO and bridge control.
`timescale 1ns/1ps

module hutb_fifo #(
  parameter int W = 8,
  parameter int D = 64
) (
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Fill side.
  input wire logic [W-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  // Drain side.
  output logic [W-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [$clog2(D):0] level_out
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic rdy_q, rdy_d, val_q, val_d, push, pop;

  always_comb begin
    push = in_valid_in & rdy_q;
    pop = val_q & out_ready_in;
    wp_d = push ? AW'(wp_q + 1'b1) : wp_q;
    rp_d = pop ? AW'(rp_q + 1'b1) : rp_q;
    cnt_d = (AW+1)'(cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    rdy_d = cnt_d < (AW+1)'(D);
    val_d = cnt_d != '0;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b1;
      val_q <= 1'b0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
      val_q <= val_d;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem[wp_q] <= in_data_in;
    end
  end

  assign in_ready_out = rdy_q;
  assign out_valid_out = val_q;
  assign out_data_out = mem[rp_q];
  assign level_out = cnt_q;
endmodule : hutb_fifo

// Operation
// - Link uses RX, TX, RTS, CTS wires.
// - Baud rates span 9600 to 4 Mbps.
// - Seventeen fixed baud rates in the table.
// - Detect baud from host traffic, adopt it.
// - Vendor command changes baud; host follows.
// - Four-wire default rate is 115200 baud.
// - After reset take configuration or detected rate.
// - Combined rate error within two percent.
// - Three-wire mode ignores RTS and CTS.
// - Three-wire host holds device CTS low.
// - UART runs beside USB as secondary channel.
// - Bridge or generic traffic over the UART.
// - Two 64-byte FIFOs, receive and transmit.
// - Extra streams and commands from primary transport.
// - Select UART when CTS seen low at boot.
// - Bit timing derives from reference clock.
// - Autobaud only when UART is host transport.
module hutb_dev
  import hutb_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Serial link.
  hutb_link_if.dev link,
  // Configuration.
  input wire logic cfg_valid_in,
  input wire logic [4:0] cfg_baud_idx_in,
  input wire logic three_wire_in,
  input wire logic bridge_mode_in,
  input wire logic autobaud_en_in,
  // Vendor rate command.
  input wire logic baud_set_valid_in,
  input wire logic [4:0] baud_set_idx_in,
  // Bytes to send on the UART.
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  // Bytes received from the UART.
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  input wire logic rx_ready_in,
  // Status.
  output logic uart_sel_out,
  output logic [4:0] baud_idx_out,
  output logic baud_locked_out,
  output logic rx_err_out
);
  localparam logic [6:0] RTS_LEVEL = 7'(HUTB_FIFO_DEPTH - HUTB_RTS_MARGIN);
  logic [2:0] cts_s_q;
  logic cts_n_q, cts_n_d, sel_q, sel_d, lock_q, lock_d, rts_n_q, rts_n_d, err_q, err_d;
  logic [4:0] idx_q, idx_d;
  logic [15:0] ab_q, ab_d;
  logic active, allow, line, ser_txd, ser_rdy, ser_rval, ser_rerr, rx_push, rx_rdy;
  logic tf_val;
  logic [7:0] tf_data, ser_rdata;
  logic [6:0] rx_lvl;

  always_comb begin
    cts_n_d = (cts_s_q[1] == cts_s_q[2]) ? cts_s_q[2] : cts_n_q;
    sel_d = sel_q | !cts_n_q;
    active = sel_q | bridge_mode_in;
    allow = active & (three_wire_in | !cts_n_q);
    idx_d = idx_q;
    lock_d = lock_q;
    ab_d = ab_q;
    if (baud_set_valid_in && int'(baud_set_idx_in) < HUTB_NRATES) begin
      idx_d = baud_set_idx_in;
      lock_d = 1'b1;
    end else if (cfg_valid_in && int'(cfg_baud_idx_in) < HUTB_NRATES) begin
      idx_d = cfg_baud_idx_in;
      lock_d = 1'b1;
    end else if (autobaud_en_in && sel_q && !lock_q) begin
      // The first low run of host traffic is taken as one bit time.
      if (!line) begin
        ab_d = (ab_q == HUTB_AB_MAX) ? ab_q : ab_q + 16'h0001;
      end else if (ab_q != 16'h0000) begin
        idx_d = hutb_nearest(ab_q);
        lock_d = 1'b1;
        ab_d = 16'h0000;
      end
    end
    // Outside bridge mode, characters are dropped, not stored, while detection is still pending.
    rx_push = ser_rval & active & (lock_q | !autobaud_en_in | bridge_mode_in);
    err_d = ser_rerr | (rx_push & !rx_rdy);
    rts_n_d = three_wire_in ? 1'b0 : (rx_lvl >= RTS_LEVEL);
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cts_s_q <= 3'h7;
      cts_n_q <= 1'b1;
      sel_q <= 1'b0;
      idx_q <= HUTB_IDX_DEFAULT;
      lock_q <= 1'b0;
      ab_q <= 16'h0000;
      rts_n_q <= 1'b1;
      err_q <= 1'b0;
    end else begin
      cts_s_q <= {cts_s_q[1:0], link.host_rts_n};
      cts_n_q <= cts_n_d;
      sel_q <= sel_d;
      idx_q <= idx_d;
      lock_q <= lock_d;
      ab_q <= ab_d;
      rts_n_q <= rts_n_d;
      err_q <= err_d;
    end
  end

  hutb_fifo #(.W(HUTB_FIFO_WIDTH), .D(HUTB_FIFO_DEPTH)) u_txf (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .in_data_in(tx_data_in), .in_valid_in(tx_valid_in), .in_ready_out(tx_ready_out),
    .out_data_out(tf_data), .out_valid_out(tf_val), .out_ready_in(ser_rdy),
    .level_out()
  );

  hutb_fifo #(.W(HUTB_FIFO_WIDTH), .D(HUTB_FIFO_DEPTH)) u_rxf (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .in_data_in(ser_rdata), .in_valid_in(rx_push), .in_ready_out(rx_rdy),
    .out_data_out(rx_data_out), .out_valid_out(rx_valid_out), .out_ready_in(rx_ready_in),
    .level_out(rx_lvl)
  );

  hutb_ser u_ser (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .div_in(hutb_div(idx_q)),
    .rxd_in(link.host_txd), .txd_out(ser_txd), .rx_line_out(line),
    .tx_data_in(tf_data), .tx_valid_in(tf_val), .tx_allow_in(allow), .tx_ready_out(ser_rdy),
    .rx_data_out(ser_rdata), .rx_valid_out(ser_rval), .rx_err_out(ser_rerr)
  );

  assign link.dev_txd = ser_txd;
  assign link.dev_rts_n = rts_n_q;
  assign uart_sel_out = sel_q;
  assign baud_idx_out = idx_q;
  assign baud_locked_out = lock_q;
  assign rx_err_out = err_q;
endmodule : hutb_dev

/* File: design/hutb_host.sv */
// Host end of the UART transport and the serial core that both ends share.
`timescale 1ns/1ps

module hutb_ser
  import hutb_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Bit timing and pins.
  input wire logic [15:0] div_in,
  input wire logic rxd_in,
  output logic txd_out,
  output logic rx_line_out,
  // Transmit byte.
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  input wire logic tx_allow_in,
  output logic tx_ready_out,
  // Received byte.
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  output logic rx_err_out
);
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} hutb_tx_e;
  typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_RECV = 2'b10} hutb_rx_e;
  hutb_tx_e tst_q, tst_d;
  hutb_rx_e rst_q, rst_d;
  logic [2:0] s_q;
  logic line_q, line_d;
  logic [9:0] tsh_q, tsh_d;
  logic [15:0] tcnt_q, tcnt_d, rcnt_q, rcnt_d;
  logic [3:0] tbit_q, tbit_d, rbit_q, rbit_d;
  logic txd_q, txd_d, trdy_q, trdy_d;
  logic [7:0] rsh_q, rsh_d;
  logic rval_q, rval_d, rerr_q, rerr_d;

  always_comb begin
    // A level change counts only once the second and third stages agree.
    line_d = (s_q[1] == s_q[2]) ? s_q[2] : line_q;
    tst_d = tst_q;
    tsh_d = tsh_q;
    tcnt_d = tcnt_q;
    tbit_d = tbit_q;
    txd_d = txd_q;
    trdy_d = trdy_q;
    unique case (tst_q)
      TX_IDLE: begin
        trdy_d = tx_allow_in;
        if (tx_valid_in && trdy_q) begin
          tsh_d = {1'b1, tx_data_in, 1'b0};
          txd_d = 1'b0;
          tcnt_d = div_in - 16'h0001;
          tbit_d = 4'h0;
          trdy_d = 1'b0;
          tst_d = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (tcnt_q != 16'h0000) begin
          tcnt_d = tcnt_q - 16'h0001;
        end else if (tbit_q == HUTB_LAST_TX_BIT) begin
          trdy_d = tx_allow_in;
          tst_d = TX_IDLE;
        end else begin
          tsh_d = {1'b1, tsh_q[9:1]};
          txd_d = tsh_q[1];
          tbit_d = tbit_q + 4'h1;
          tcnt_d = div_in - 16'h0001;
        end
      end
    endcase
    rst_d = rst_q;
    rcnt_d = rcnt_q;
    rbit_d = rbit_q;
    rsh_d = rsh_q;
    rval_d = 1'b0;
    rerr_d = 1'b0;
    unique case (rst_q)
      RX_IDLE: begin
        if (!line_q) begin
          rcnt_d = {1'b0, div_in[15:1]};
          rbit_d = 4'h0;
          rst_d = RX_RECV;
        end
      end
      RX_RECV: begin
        if (rcnt_q != 16'h0000) begin
          rcnt_d = rcnt_q - 16'h0001;
        end else begin
          rcnt_d = div_in - 16'h0001;
          if (rbit_q == 4'h0) begin
            // A start bit that is high again at mid-bit was a glitch.
            rst_d = line_q ? RX_IDLE : RX_RECV;
            rbit_d = 4'h1;
          end else if (rbit_q <= HUTB_LAST_RX_DATA) begin
            rsh_d = {line_q, rsh_q[7:1]};
            rbit_d = rbit_q + 4'h1;
          end else begin
            rval_d = line_q;
            rerr_d = !line_q;
            rst_d = RX_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_q <= 3'h7;
      line_q <= 1'b1;
      tst_q <= TX_IDLE;
      tsh_q <= 10'h3FF;
      tcnt_q <= 16'h0000;
      tbit_q <= 4'h0;
      txd_q <= 1'b1;
      trdy_q <= 1'b0;
      rst_q <= RX_IDLE;
      rcnt_q <= 16'h0000;
      rbit_q <= 4'h0;
      rsh_q <= 8'h00;
      rval_q <= 1'b0;
      rerr_q <= 1'b0;
    end else begin
      s_q <= {s_q[1:0], rxd_in};
      line_q <= line_d;
      tst_q <= tst_d;
      tsh_q <= tsh_d;
      tcnt_q <= tcnt_d;
      tbit_q <= tbit_d;
      txd_q <= txd_d;
      trdy_q <= trdy_d;
      rst_q <= rst_d;
      rcnt_q <= rcnt_d;
      rbit_q <= rbit_d;
      rsh_q <= rsh_d;
      rval_q <= rval_d;
      rerr_q <= rerr_d;
    end
  end

  assign txd_out = txd_q;
  assign rx_line_out = line_q;
  assign tx_ready_out = trdy_q;
  assign rx_data_out = rsh_q;
  assign rx_valid_out = rval_q;
  assign rx_err_out = rerr_q;
endmodule : hutb_ser

module hutb_host
  import hutb_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Serial link.
  hutb_link_if.host link,
  // Configuration.
  input wire logic [4:0] baud_idx_in,
  input wire logic three_wire_in,
  // Bytes to send.
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  // Bytes received.
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  input wire logic rx_ready_in,
  output logic rx_overrun_out
);
  logic [2:0] cts_s_q;
  logic cts_n_q, cts_n_d, hv_q, hv_d, rts_n_q, rts_n_d, ovr_q, ovr_d;
  logic [7:0] hd_q, hd_d, ser_rdata;
  logic ser_txd, ser_rval;

  always_comb begin
    cts_n_d = (cts_s_q[1] == cts_s_q[2]) ? cts_s_q[2] : cts_n_q;
    hv_d = hv_q & !rx_ready_in;
    hd_d = hd_q;
    ovr_d = 1'b0;
    if (ser_rval) begin
      ovr_d = hv_d;
      hv_d = 1'b1;
      hd_d = ser_rdata;
    end
    // In three-wire mode the device's CTS must sit low.
    rts_n_d = three_wire_in ? 1'b0 : hv_d;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cts_s_q <= 3'h7;
      cts_n_q <= 1'b1;
      hv_q <= 1'b0;
      hd_q <= 8'h00;
      rts_n_q <= 1'b1;
      ovr_q <= 1'b0;
    end else begin
      cts_s_q <= {cts_s_q[1:0], link.dev_rts_n};
      cts_n_q <= cts_n_d;
      hv_q <= hv_d;
      hd_q <= hd_d;
      rts_n_q <= rts_n_d;
      ovr_q <= ovr_d;
    end
  end

  hutb_ser u_ser (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .div_in(hutb_div(baud_idx_in)),
    .rxd_in(link.dev_txd), .txd_out(ser_txd), .rx_line_out(),
    .tx_data_in(tx_data_in), .tx_valid_in(tx_valid_in),
    .tx_allow_in(three_wire_in | !cts_n_q),
    .tx_ready_out(tx_ready_out),
    .rx_data_out(ser_rdata), .rx_valid_out(ser_rval), .rx_err_out()
  );

  assign link.host_txd = ser_txd;
  assign link.host_rts_n = rts_n_q;
  assign rx_data_out = hd_q;
  assign rx_valid_out = hv_q;
  assign rx_overrun_out = ovr_q;
endmodule : hutb_host

/* File: verification/hutb_link_sva.sv */
// Concurrent checks on the four serial link wires between the two ends.
`timescale 1ns/1ps
module hutb_link_sva #(
  parameter int DIV = 50
) (
  // Clock and reset.
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Link wires.
  input wire logic dev_txd,
  input wire logic host_txd,
  input wire logic dev_rts_n,
  input wire logic host_rts_n
);
  logic [1:0] line;
  logic [1:0] prev_q;
  logic [15:0] pos_q [2];
  logic [15:0] low_q [2];

  assign line = {host_txd, dev_txd};

  // Frame position counters find bit centres without long repetitions in the properties.
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prev_q <= 2'h3;
      pos_q <= '{default: 16'h0};
      low_q <= '{default: 16'h0};
    end else begin
      prev_q <= line;
      for (int i = 0; i < 2; i++) begin
        low_q[i] <= line[i] ? 16'h0 : low_q[i] + 16'h1;
        if (pos_q[i] != 16'h0) begin
          pos_q[i] <= pos_q[i] - 16'h1;
        end else if (prev_q[i] && !line[i]) begin
          pos_q[i] <= 16'(10 * DIV - 1);
        end
      end
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  sequence dev_cts_held;
    host_rts_n [*8];
  endsequence
  sequence host_cts_held;
    dev_rts_n [*8];
  endsequence

  chk_reset_idle: assert property ($fell(rst_in) |-> dev_txd && host_txd)
    else $error("link not idle after reset");
  chk_dev_start_bit: assert property (pos_q[0] == 16'(10 * DIV - DIV / 2) |-> !dev_txd)
    else $error("device start bit not low at its centre");
  chk_dev_stop_bit: assert property (pos_q[0] == 16'(DIV / 2) |-> dev_txd)
    else $error("device stop bit not high at its centre");
  chk_host_start_bit: assert property (pos_q[1] == 16'(10 * DIV - DIV / 2) |-> !host_txd)
    else $error("host start bit not low at its centre");
  chk_host_stop_bit: assert property (pos_q[1] == 16'(DIV / 2) |-> host_txd)
    else $error("host stop bit not high at its centre");
  chk_dev_bit_len: assert property ($rose(dev_txd) |-> low_q[0] % DIV == 0 && low_q[0] <= 9 * DIV)
    else $error("device low run not whole bit times");
  chk_host_bit_len: assert property ($rose(host_txd) |-> low_q[1] % DIV == 0 && low_q[1] <= 9 * DIV)
    else $error("host low run not whole bit times");
  chk_dev_cts_gate: assert property (dev_cts_held ##1 (pos_q[0] == 16'h0 && dev_txd) |=> dev_txd)
    else $error("device started a character while held off");
  chk_host_cts_gate: assert property (host_cts_held ##1 (pos_q[1] == 16'h0 && host_txd) |=> host_txd)
    else $error("host started a character while held off");
endmodule : hutb_link_sva

/* File: verification/hci_uart_transport_bridge_tb_top.sv */
// Self-checking bench: device and host ends joined over the serial link.
`timescale 1ns/1ps
module hci_uart_transport_bridge_tb_top;
  import hutb_pkg::*;
  localparam int FAST_DIV = 50;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic cfg_valid = 1'b0;
  logic [4:0] cfg_idx = 5'h00;
  logic dev_three = 1'b0;
  logic ab_en = 1'b0;
  logic h_three = 1'b0;
  logic set_valid = 1'b0;
  logic [4:0] set_idx = 5'h00;
  logic [7:0] d_tx_data = 8'h00;
  logic d_tx_valid = 1'b0;
  logic d_tx_rdy;
  logic [7:0] d_rx_data;
  logic d_rx_valid;
  logic d_rx_rdy = 1'b1;
  logic uart_sel;
  logic [4:0] baud_idx;
  logic locked;
  logic d_err;
  logic [7:0] h_tx_data = 8'h00;
  logic h_tx_valid = 1'b0;
  logic h_tx_rdy;
  logic [7:0] h_rx_data;
  logic h_rx_valid;
  logic h_rx_rdy = 1'b1;
  logic h_ovr;
  int n_errors = 0;
  int total_checks = 0;
  int seed = 32'hd915;
  logic [7:0] d2h_q[$];
  logic [7:0] h2d_q[$];

  hutb_link_if u_hutb_link_if();
  hutb_dev u_hutb_dev(.ref_clk_in(ref_clk_in), .rst_in(rst_in), .link(u_hutb_link_if.dev),
    .cfg_valid_in(cfg_valid), .cfg_baud_idx_in(cfg_idx), .three_wire_in(dev_three),
    .bridge_mode_in(1'b0), .autobaud_en_in(ab_en), .baud_set_valid_in(set_valid),
    .baud_set_idx_in(set_idx), .tx_data_in(d_tx_data), .tx_valid_in(d_tx_valid),
    .tx_ready_out(d_tx_rdy), .rx_data_out(d_rx_data), .rx_valid_out(d_rx_valid),
    .rx_ready_in(d_rx_rdy), .uart_sel_out(uart_sel), .baud_idx_out(baud_idx),
    .baud_locked_out(locked), .rx_err_out(d_err));
  hutb_host u_hutb_host(.ref_clk_in(ref_clk_in), .rst_in(rst_in), .link(u_hutb_link_if.host),
    .baud_idx_in(5'h10), .three_wire_in(h_three), .tx_data_in(h_tx_data),
    .tx_valid_in(h_tx_valid), .tx_ready_out(h_tx_rdy), .rx_data_out(h_rx_data),
    .rx_valid_out(h_rx_valid), .rx_ready_in(h_rx_rdy), .rx_overrun_out(h_ovr));
  hutb_link_sva #(.DIV(FAST_DIV)) u_hutb_link_sva(.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .dev_txd(u_hutb_link_if.dev_txd), .host_txd(u_hutb_link_if.host_txd),
    .dev_rts_n(u_hutb_link_if.dev_rts_n), .host_rts_n(u_hutb_link_if.host_rts_n));

  always #2.5 ref_clk_in = ~ref_clk_in;

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("Checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  // An empty queue yields an unknown, so an unexpected byte never passes.
  always @(posedge ref_clk_in) begin
    if (d_rx_valid === 1'b1 && d_rx_rdy)
      check("dev_rx_data", d_rx_data, h2d_q.size() ? h2d_q.pop_front() : 8'hXX);
    if (h_rx_valid === 1'b1 && h_rx_rdy)
      check("host_rx_data", h_rx_data, d2h_q.size() ? d2h_q.pop_front() : 8'hXX);
    if (!rst_in && (d_err !== 1'b0 || h_ovr !== 1'b0))
      check("link_error", {6'h0, d_err, h_ovr}, 8'h00);
  end

  task automatic send(input bit dev_side, input logic [7:0] b);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    if (dev_side) begin
      d_tx_data <= b;
      d_tx_valid <= 1'b1;
      d2h_q.push_back(b);
    end else begin
      h_tx_data <= b;
      h_tx_valid <= 1'b1;
      h2d_q.push_back(b);
    end
    do begin
      @(posedge ref_clk_in);
      n++;
    end while ((dev_side ? d_tx_rdy : h_tx_rdy) !== 1'b1 && n < 5000);
    check("send_taken", {7'h0, n < 5000}, 8'h01);
    if (dev_side)
      d_tx_valid <= 1'b0;
    else
      h_tx_valid <= 1'b0;
  endtask : send

  task automatic rate(input bit sv, input logic [4:0] si, input bit cv, input logic [4:0] ci,
                      input logic [4:0] exp);
    @(posedge ref_clk_in);
    set_valid <= sv;
    set_idx <= si;
    cfg_valid <= cv;
    cfg_idx <= ci;
    @(posedge ref_clk_in);
    set_valid <= 1'b0;
    cfg_valid <= 1'b0;
    @(posedge ref_clk_in);
    check("baud_idx", {3'h0, baud_idx}, {3'h0, exp});
  endtask : rate

  task automatic drain();
    int n;
    n = 0;
    while ((d2h_q.size() || h2d_q.size()) && n < 60000) begin
      @(posedge ref_clk_in);
      n++;
    end
    check("drained", {7'h0, n < 60000}, 8'h01);
  endtask : drain

  initial begin
    repeat (100000) @(posedge ref_clk_in);
    n_errors++;
    complete_run();
  end

  initial begin
    repeat (20) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    rst_in = 1'b0;
    @(posedge ref_clk_in);
    check("baud_reset", {3'h0, baud_idx}, 8'h06);
    check("locked_reset", {7'h0, locked}, 8'h00);
    repeat (30) @(posedge ref_clk_in);
    check("uart_sel", {7'h0, uart_sel}, 8'h01);
    // Index 17 is outside the table and must leave the last rate in place.
    for (int i = 0; i < 18; i++)
      rate(1'b1, 5'(i), 1'b0, 5'h00, (i < 17) ? 5'(i) : 5'h10);
    rate(1'b0, 5'h00, 1'b1, 5'h1F, 5'h10);
    rate(1'b1, 5'h02, 1'b1, 5'h05, 5'h02);
    rate(1'b0, 5'h00, 1'b1, 5'h10, 5'h10);
    check("locked", {7'h0, locked}, 8'h01);
    fork
      for (int k = 0; k < 8; k++)
        send(1'b1, (k == 0) ? 8'h00 : 8'($random(seed)));
      for (int k = 0; k < 8; k++)
        send(1'b0, (k == 7) ? 8'hFF : 8'($random(seed)));
    join
    drain();
    // Host holding register full: the device must wait rather than overrun it.
    h_rx_rdy <= 1'b0;
    send(1'b1, 8'($random(seed)));
    repeat (700) @(posedge ref_clk_in);
    check("host_rts_full", {7'h0, u_hutb_link_if.host_rts_n}, 8'h01);
    // In three-wire mode the host must hold the device's CTS low even when full.
    h_three <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    check("host_rts_3w", {7'h0, u_hutb_link_if.host_rts_n}, 8'h00);
    h_three <= 1'b0;
    repeat (20) @(posedge ref_clk_in);
    send(1'b1, 8'($random(seed)));
    repeat (1200) @(posedge ref_clk_in);
    h_rx_rdy <= 1'b1;
    drain();
    d_rx_rdy <= 1'b0;
    for (int k = 0; k < 60; k++)
      send(1'b0, 8'($random(seed)));
    repeat (700) @(posedge ref_clk_in);
    check("dev_rts_full", {7'h0, u_hutb_link_if.dev_rts_n}, 8'h01);
    dev_three <= 1'b1;
    repeat (8) @(posedge ref_clk_in);
    check("dev_rts_3w", {7'h0, u_hutb_link_if.dev_rts_n}, 8'h00);
    dev_three <= 1'b0;
    repeat (20) @(posedge ref_clk_in);
    fork
      send(1'b0, 8'($random(seed)));
    join_none
    repeat (2000) @(posedge ref_clk_in);
    d_rx_rdy <= 1'b1;
    drain();
    // Second reset: the rate must now come from the first host character.
    @(posedge ref_clk_in);
    rst_in <= 1'b1;
    ab_en <= 1'b1;
    repeat (20) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    rst_in = 1'b0;
    repeat (30) @(posedge ref_clk_in);
    check("locked_ab_idle", {7'h0, locked}, 8'h00);
    // The probe character is measured, not delivered, so it leaves no expectation.
    send(1'b0, 8'h01);
    void'(h2d_q.pop_back());
    repeat (1000) @(posedge ref_clk_in);
    check("baud_ab", {3'h0, baud_idx}, 8'h10);
    check("locked_ab", {7'h0, locked}, 8'h01);
    send(1'b0, 8'($random(seed)));
    drain();
    complete_run();
  end
endmodule : hci_uart_transport_bridge_tb_top
